// >>> hw/rss_consts.vh
// offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH

// register byte offsets
`define RSS_OFF_CAUSE   8'h00
`define RSS_OFF_DROOP   8'h04
`define RSS_OFF_DLY     8'h08
`define RSS_OFF_SYS     8'h0c
`define RSS_OFF_PERIPH  8'h10
`define RSS_OFF_STAT    8'h14

// reset_cause_flags bit positions, one per source
`define RSS_NCAUSE      6
`define RSS_C_EXT       0
`define RSS_C_POR       1
`define RSS_C_DROOP     2
`define RSS_C_SW        3
`define RSS_C_WDOG      4
`define RSS_C_LDO       5

// droop control fields
`define RSS_B_DWAIT     0
`define RSS_B_DSEL      1

// system control fields
`define RSS_B_SWREQ     0
`define RSS_B_LDOEN     1

// reset values
`define RSS_RST_CAUSE   6'h00
`define RSS_RST_DLY     16'h0100
`define RSS_RST_PERIPH  8'h00

// timing: settle window 15 to 30 ms, 20 ms chosen, counted in main_osc ticks
`define RSS_SETTLE_MS     20
`define RSS_MAIN_OSC_KHZ  8000
`define RSS_SETTLE_TICKS  (`RSS_SETTLE_MS * `RSS_MAIN_OSC_KHZ)
// timing: droop blanking after a brown-out, counted in internal_osc cycles
`define RSS_CLK_MHZ       25
`define RSS_DROOP_CLR_US  500
`define RSS_DROOP_CLR_CYC (`RSS_DROOP_CLR_US * `RSS_CLK_MHZ)
// internal reset hold for internally generated resets, in clock cycles
`define RSS_INT_HOLD_CYC  16

`endif

// >>> hw/rss_timer.v
// loadable down-counter with expiry pulse
`timescale 1ns/1ps
module rss_timer #(
   parameter TW = 20                 // counter width
) (
   input  wire          clk_i,       // internal_osc clock
   input  wire          nrst_i,      // async reset, active low
   input  wire          load_i,      // start a new count
   input  wire [TW-1:0] val_i,       // count to load
   input  wire          step_i,      // one count per high cycle
   output wire          busy_o,      // counting
   output wire          done_o       // one-cycle pulse at expiry
);
   reg [TW-1:0] cnt_r;               // remaining steps
   reg          busy_r;              // running flag
   reg          done_r;              // expiry pulse

   assign busy_o = busy_r;
   assign done_o = done_r;

   // count down; a zero load still lasts one step so no window is empty
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_r  <= {TW{1'b0}};
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (load_i) begin
            cnt_r  <= (val_i == {TW{1'b0}}) ? {{(TW-1){1'b0}}, 1'b1} : val_i;
            busy_r <= 1'b1;
         end else if (busy_r && step_i) begin
            // last step ends the count
            if (cnt_r == {{(TW-1){1'b0}}, 1'b1}) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end
            cnt_r <= cnt_r - {{(TW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule

// >>> hw/rss_seq.v
// reset sources, settle timing, cause flags, boot release
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rss_consts.vh"

// What this block does
// - six sources: pin, power-on, droop, software, watchdog, regulator
// - set cause flag when reset completes
// - cause flags stay set across resets other than pin reset
// - pin reset leaves only its own flag
// - pin/power-on timed by main_osc, others internal
// - pin reset spares the test port
// - settle count after pin release holds reset
// - release: fetch stack, counter, first instruction
// - power-on waits for later of pin, detector
// - settle count after both power-on inputs clear
// - power-on detector honoured on first power-up only
// - power-on also resets the test port
// - droop wait option resamples after programmed delay if droop_reset_select clear
// - droop condition cleared 500 us later
// - set then clear resets one peripheral
// - watchdog resets on uncleared second time-out
module rss_seq #(
   parameter          TW            = 20,                  // timer width
   parameter          NPERIPH       = 8,                   // soft-reset lanes
   parameter [TW-1:0] SETTLE_TICKS  = `RSS_SETTLE_TICKS,   // main_osc ticks
   parameter [TW-1:0] DROOP_CLR_CYC = `RSS_DROOP_CLR_CYC   // blanking cycles
) (
   input  wire               clk_i,            // internal_osc, 25 MHz
   input  wire               nrst_i,           // block reset, active low
   input  wire [7:0]         addr_i,           // register byte address
   input  wire [31:0]        wdata_i,          // write data
   input  wire               wr_i,             // write strobe
   input  wire               rd_i,             // read strobe
   output wire [31:0]        rdata_o,          // read data, cycle after rd_i
   input  wire               ext_rst_n_i,      // external reset pin
   input  wire               por_i,            // power-on detector, high active
   input  wire               droop_det_i,      // supply droop comparator
   input  wire               wdog_timeout_i,   // watchdog time-out pulse
   input  wire               wdog_int_pend_i,  // first time-out still uncleared
   input  wire               wdog_rst_en_i,    // watchdog reset output enabled
   input  wire               ldo_unreg_i,      // regulator out of regulation
   input  wire               main_osc_tick_i,  // one pulse per main_osc cycle
   output wire               core_rst_n_o,     // core reset, active low
   output wire [NPERIPH-1:0] periph_rst_o,     // peripheral resets, high
   output wire               test_rst_n_o,     // test port reset, active low
   output wire [1:0]         boot_step_o       // 1 stack, 2 counter, 3 instr
);
   // sequencer states
   localparam [2:0] S_PIN    = 3'h0;  // wait pin and power-on inactive
   localparam [2:0] S_SETTLE = 3'h1;  // main_osc settle count
   localparam [2:0] S_IHOLD  = 3'h2;  // internal reset hold
   localparam [2:0] S_SP     = 3'h3;  // fetch initial stack pointer
   localparam [2:0] S_PC     = 3'h4;  // fetch initial program counter
   localparam [2:0] S_INS    = 3'h5;  // fetch first instruction
   localparam [2:0] S_RUN    = 3'h6;  // running

   // droop states
   localparam [1:0] D_IDLE  = 2'h0;   // watching comparator
   localparam [1:0] D_WAIT  = 2'h1;   // resample delay
   localparam [1:0] D_BLANK = 2'h2;   // blanking after a droop

   localparam NC = `RSS_NCAUSE;
   localparam [TW-1:0] INT_HOLD = `RSS_INT_HOLD_CYC;

   // reset held to the core in these states
   function in_rst;
      input [2:0] st;
      begin
         in_rst = (st == S_PIN) || (st == S_SETTLE) || (st == S_IHOLD);
      end
   endfunction

   // one-hot cause from bit index
   function [NC-1:0] cause_bit;
      input integer idx;
      begin
         cause_bit = {{(NC-1){1'b0}}, 1'b1} << idx;
      end
   endfunction

   // pin synchroniser
   reg               ext_s1_r;         // first stage, read only by second
   reg               ext_s2_r;         // synchronised pin level
   // sequencer
   reg  [2:0]        state_r;          // current state
   reg  [2:0]        state_nxt;        // next state
   reg  [NC-1:0]     pend_r;           // cause of reset in progress
   reg  [NC-1:0]     pend_nxt;         // next cause
   reg               por_seen_r;       // power-on detector already released
   // registers
   reg  [NC-1:0]     cause_r;          // reset_cause_flags
   reg               dwait_r;          // droop_wait_enable
   reg               dsel_r;           // droop_reset_select
   reg  [15:0]       dly_r;            // droop_resample_delay, clk cycles
   reg               swreq_r;          // software system reset request
   reg               ldoen_r;          // regulator reset enable
   reg  [NPERIPH-1:0] psoft_r;         // peripheral_soft_reset_ctl
   reg  [31:0]       rdata_r;          // read data
   // outputs
   reg               core_rst_n_r;     // core reset
   reg  [NPERIPH-1:0] periph_rst_r;    // peripheral resets
   reg               test_rst_n_r;     // test port reset
   reg  [1:0]        boot_step_r;      // boot fetch step
   // droop
   reg  [1:0]        dstate_r;         // droop state
   reg               dcond_r;          // internal droop condition
   reg               dtrip_r;          // confirmed droop reset request
   // timers
   reg               tm_load;          // sequencer timer load
   reg  [TW-1:0]     tm_val;           // sequencer timer value
   reg               tm_step;          // sequencer timer step
   wire              tm_done;          // sequencer timer expiry
   reg               dt_load;          // droop timer load
   reg  [TW-1:0]     dt_val;           // droop timer value
   wire              dt_done;          // droop timer expiry
   // request decode
   wire              pin_low;          // pin asserted, synchronised
   wire              por_act;          // power-on detector still honoured
   wire              wdog_trip;        // watchdog reset request
   wire              ldo_trip;         // regulator reset request
   wire              wr_cause;         // write to flag register
   reg  [NC-1:0]     cause_set;        // flags to set this cycle

   assign rdata_o      = rdata_r;
   assign core_rst_n_o = core_rst_n_r;
   assign periph_rst_o = periph_rst_r;
   assign test_rst_n_o = test_rst_n_r;
   assign boot_step_o  = boot_step_r;

   // two-flop pin synchroniser
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ext_s1_r <= 1'b0;
         ext_s2_r <= 1'b0;
      end else begin
         ext_s1_r <= ext_rst_n_i;
         ext_s2_r <= ext_s1_r;
      end
   end

   assign pin_low   = !ext_s2_r;
   // detector honoured on first power-up only
   assign por_act   = por_i && !por_seen_r;
   // second uncleared time-out, reset enabled
   assign wdog_trip = wdog_timeout_i && wdog_int_pend_i && wdog_rst_en_i;
   assign ldo_trip  = ldo_unreg_i && ldoen_r;
   assign wr_cause  = wr_i && (addr_i == `RSS_OFF_CAUSE);

   // sequencer next state, timer control
   always @* begin
      state_nxt = state_r;
      pend_nxt  = pend_r;
      tm_load   = 1'b0;
      tm_val    = INT_HOLD;
      tm_step   = 1'b1;
      case (state_r)
         S_PIN: begin
            // wait for later of pin and detector
            if (!pin_low && !por_act) begin
               state_nxt = S_SETTLE;
               tm_load   = 1'b1;
               tm_val    = SETTLE_TICKS;
            end
         end
         S_SETTLE: begin
            // pin/power-on count main_osc ticks
            tm_step = main_osc_tick_i;
            if (pin_low) begin
               state_nxt = S_PIN;
            end else if (tm_done) begin
               state_nxt = S_SP;
            end
         end
         S_IHOLD: begin
            // internal resets count clk cycles
            if (pin_low) begin
               state_nxt = S_PIN;
               pend_nxt  = cause_bit(`RSS_C_EXT);
            end else if (tm_done) begin
               state_nxt = S_SP;
            end
         end
         S_SP: begin
            // boot fetches follow release in fixed order
            state_nxt = S_PC;
         end
         S_PC: begin
            state_nxt = S_INS;
         end
         S_INS: begin
            state_nxt = S_RUN;
         end
         S_RUN: begin
            // pin first, then droop, regulator, watchdog, software
            if (pin_low) begin
               state_nxt = S_PIN;
               pend_nxt  = cause_bit(`RSS_C_EXT);
            end else if (dtrip_r) begin
               state_nxt = S_IHOLD;
               pend_nxt  = cause_bit(`RSS_C_DROOP);
               tm_load   = 1'b1;
            end else if (ldo_trip) begin
               state_nxt = S_IHOLD;
               pend_nxt  = cause_bit(`RSS_C_LDO);
               tm_load   = 1'b1;
            end else if (wdog_trip) begin
               state_nxt = S_IHOLD;
               pend_nxt  = cause_bit(`RSS_C_WDOG);
               tm_load   = 1'b1;
            end else if (swreq_r) begin
               state_nxt = S_IHOLD;
               pend_nxt  = cause_bit(`RSS_C_SW);
               tm_load   = 1'b1;
            end
         end
         default: begin
            state_nxt = S_PIN;
         end
      endcase
      // pin press in power-on keeps that cause
      if (state_r == S_SETTLE && pin_low && !pend_r[`RSS_C_POR]) begin
         pend_nxt = cause_bit(`RSS_C_EXT);
      end
   end

   // flags to set at completion of a reset
   always @* begin
      cause_set = {NC{1'b0}};
      if (state_nxt == S_SP && state_r != S_SP) begin
         cause_set = pend_r;
      end
   end

   // sequencer registers and outputs
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_r      <= S_PIN;
         pend_r       <= cause_bit(`RSS_C_POR);
         por_seen_r   <= 1'b0;
         core_rst_n_r <= 1'b0;
         periph_rst_r <= {NPERIPH{1'b1}};
         test_rst_n_r <= 1'b0;
         boot_step_r  <= 2'h0;
      end else begin
         state_r <= state_nxt;
         pend_r  <= pend_nxt;
         if (state_r == S_SETTLE) begin
            por_seen_r <= 1'b1;
         end
         core_rst_n_r <= !in_rst(state_nxt);
         // system reset plus soft lanes
         periph_rst_r <= {NPERIPH{in_rst(state_nxt)}} | psoft_r;
         // test port reset by power-on only
         test_rst_n_r <= !(in_rst(state_nxt) && pend_nxt[`RSS_C_POR]);
         case (state_nxt)
            S_SP:    boot_step_r <= 2'h1;
            S_PC:    boot_step_r <= 2'h2;
            S_INS:   boot_step_r <= 2'h3;
            default: boot_step_r <= 2'h0;
         endcase
      end
   end

   // droop timer control
   always @* begin
      dt_load = 1'b0;
      dt_val  = DROOP_CLR_CYC;
      case (dstate_r)
         D_IDLE: begin
            if (droop_det_i) begin
               dt_load = 1'b1;
               if (dwait_r && !dsel_r) begin
                  dt_val = {{(TW-16){1'b0}}, dly_r};
               end
            end
         end
         D_WAIT: begin
            // confirmed droop: blanking
            if (dt_done && droop_det_i) begin
               dt_load = 1'b1;
            end
         end
         default: begin
            dt_load = 1'b0;
         end
      endcase
   end

   // droop condition, resample and blanking
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dstate_r <= D_IDLE;
         dcond_r  <= 1'b0;
         dtrip_r  <= 1'b0;
      end else begin
         // held until the sequencer is free to take it
         if (state_r == S_RUN && !pin_low) begin
            dtrip_r <= 1'b0;
         end
         case (dstate_r)
            D_IDLE: begin
               if (droop_det_i) begin
                  dcond_r <= 1'b1;
                  if (dwait_r && !dsel_r) begin
                     dstate_r <= D_WAIT;
                  end else begin
                     dstate_r <= D_BLANK;
                     dtrip_r  <= dsel_r;
                  end
               end
            end
            D_WAIT: begin
               if (dt_done) begin
                  if (droop_det_i) begin
                     dstate_r <= D_BLANK;
                     dtrip_r  <= 1'b1;
                  end else begin
                     // noise: no further action
                     dstate_r <= D_IDLE;
                     dcond_r  <= 1'b0;
                  end
               end
            end
            D_BLANK: begin
               // no new droop registered until software can look
               if (dt_done) begin
                  dstate_r <= D_IDLE;
                  dcond_r  <= 1'b0;
               end
            end
            default: begin
               dstate_r <= D_IDLE;
            end
         endcase
      end
   end

   // reset_cause_flags: sticky, write one to clear, set wins
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cause_r <= `RSS_RST_CAUSE;
      end else if (cause_set[`RSS_C_EXT]) begin
         cause_r <= cause_bit(`RSS_C_EXT);
      end else if (wr_cause) begin
         cause_r <= (cause_r & ~wdata_i[NC-1:0]) | cause_set;
      end else begin
         cause_r <= cause_r | cause_set;
      end
   end

   // control register writes
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dwait_r <= 1'b0;
         dsel_r  <= 1'b0;
         dly_r   <= `RSS_RST_DLY;
         swreq_r <= 1'b0;
         ldoen_r <= 1'b0;
         psoft_r <= `RSS_RST_PERIPH;
      end else begin
         // cleared when taken
         if (state_r == S_RUN && pend_nxt[`RSS_C_SW] && state_nxt == S_IHOLD) begin
            swreq_r <= 1'b0;
         end
         if (wr_i) begin
            case (addr_i)
               `RSS_OFF_DROOP: begin
                  dwait_r <= wdata_i[`RSS_B_DWAIT];
                  dsel_r  <= wdata_i[`RSS_B_DSEL];
               end
               `RSS_OFF_DLY: begin
                  dly_r <= wdata_i[15:0];
               end
               `RSS_OFF_SYS: begin
                  if (wdata_i[`RSS_B_SWREQ]) begin
                     swreq_r <= 1'b1;
                  end
                  ldoen_r <= wdata_i[`RSS_B_LDOEN];
               end
               `RSS_OFF_PERIPH: begin
                  psoft_r <= wdata_i[NPERIPH-1:0];
               end
               default: begin
                  dly_r <= dly_r;
               end
            endcase
         end
      end
   end

   // read data for one cycle only
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= 32'h0;
         if (rd_i) begin
            case (addr_i)
               `RSS_OFF_CAUSE:  rdata_r <= {{(32-NC){1'b0}}, cause_r};
               `RSS_OFF_DROOP:  rdata_r <= {30'h0, dsel_r, dwait_r};
               `RSS_OFF_DLY:    rdata_r <= {16'h0, dly_r};
               `RSS_OFF_SYS:    rdata_r <= {30'h0, ldoen_r, swreq_r};
               `RSS_OFF_PERIPH: rdata_r <= {{(32-NPERIPH){1'b0}}, psoft_r};
               `RSS_OFF_STAT:   rdata_r <= {26'h0, !test_rst_n_r, por_seen_r,
                                            dcond_r, state_r};
               default:         rdata_r <= 32'h0;
            endcase
         end
      end
   end

   // settle and internal hold share one timer; never both at once
   rss_timer #(
      .TW     (TW)
   ) u_seq_tm (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .load_i (tm_load),
      .val_i  (tm_val),
      .step_i (tm_step),
      .busy_o (),
      .done_o (tm_done)
   );

   // resample delay and blanking window share the droop timer
   rss_timer #(
      .TW     (TW)
   ) u_droop_tm (
      .clk_i  (clk_i),
      .nrst_i (nrst_i),
      .load_i (dt_load),
      .val_i  (dt_val),
      .step_i (1'b1),
      .busy_o (),
      .done_o (dt_done)
   );
endmodule

// >>> verification/rss_seq_properties.sv
// reset sequencer checker
`timescale 1ns/1ps
module rss_seq_props #(
   parameter int            TW           = 20,  // timer width
   parameter int            NPERIPH      = 8,   // soft-reset lanes
   parameter logic [TW-1:0] SETTLE_TICKS = 160000  // main_osc ticks to settle
) (
   input wire logic               clk_i,
   input wire logic               nrst_i,
   input wire logic               rd_i,
   input wire logic [31:0]        rdata_o,
   input wire logic               ext_rst_n_i,
   input wire logic               por_i,
   input wire logic               wdog_timeout_i,
   input wire logic               wdog_int_pend_i,
   input wire logic               wdog_rst_en_i,
   input wire logic               main_osc_tick_i,
   input wire logic               core_rst_n_o,
   input wire logic [NPERIPH-1:0] periph_rst_o,
   input wire logic               test_rst_n_o,
   input wire logic [1:0]         boot_step_o
);
   logic [TW-1:0] ticks_r;    // ticks since pin and detector quiet
   logic          pin_seq_r;  // current reset came from pin or power-on
   logic          wd_take;    // qualified watchdog trip
   assign wd_take = wdog_timeout_i && wdog_int_pend_i && wdog_rst_en_i && core_rst_n_o
                    && boot_step_o == 2'h0;
   // raw pin: never short of synced count
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ticks_r   <= '0;
         pin_seq_r <= 1'b1;
      end else if (!ext_rst_n_i || por_i) begin
         ticks_r   <= '0;
         pin_seq_r <= 1'b1;
      end else begin
         if (!core_rst_n_o && main_osc_tick_i && ticks_r != '1) begin
            ticks_r <= ticks_r + 1'b1;
         end
         if (core_rst_n_o) begin
            pin_seq_r <= 1'b0;
         end
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   AST_BOOT_ORDER: assert property (boot_step_o == 2'h1 |=> boot_step_o == 2'h2 ##1
      boot_step_o == 2'h3 ##1 boot_step_o == 2'h0) else $error("boot fetch order broken");
   AST_RELEASE_BOOT: assert property ($rose(core_rst_n_o) |-> boot_step_o == 2'h1)
      else $error("release without stack fetch");
   AST_SETTLE: assert property ($rose(core_rst_n_o) && pin_seq_r |-> ticks_r >= SETTLE_TICKS)
      else $error("released before settle count");
   AST_PIN_HOLD: assert property (!ext_rst_n_i && !core_rst_n_o |=> !core_rst_n_o)
      else $error("core released while pin low");
   AST_PIN_TAKEN: assert property ((!ext_rst_n_i)[*8] |-> !core_rst_n_o)
      else $error("pin low did not reset core");
   AST_POR_HOLD: assert property (por_i && !core_rst_n_o |=> !core_rst_n_o)
      else $error("core released while detector active");
   AST_TEST_KEPT: assert property (!$fell(test_rst_n_o))
      else $error("test port reset after power-up");
   AST_PERIPH_CORE: assert property (!core_rst_n_o |-> &periph_rst_o)
      else $error("peripheral free in core reset");
   AST_WDOG_TAKEN: assert property (wd_take |-> ##[1:4] !core_rst_n_o)
      else $error("watchdog reset not taken");
   AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
      else $error("read data outside read slot");
   cover property ($rose(core_rst_n_o) && pin_seq_r);
   cover property (wd_take);
   cover property (boot_step_o == 2'h3);
endmodule

bind rss_seq rss_seq_props #(.TW(TW), .NPERIPH(NPERIPH), .SETTLE_TICKS(SETTLE_TICKS)) u_props (
   .clk_i(clk_i), .nrst_i(nrst_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .ext_rst_n_i(ext_rst_n_i), .por_i(por_i), .wdog_timeout_i(wdog_timeout_i),
   .wdog_int_pend_i(wdog_int_pend_i), .wdog_rst_en_i(wdog_rst_en_i),
   .main_osc_tick_i(main_osc_tick_i), .core_rst_n_o(core_rst_n_o),
   .periph_rst_o(periph_rst_o), .test_rst_n_o(test_rst_n_o), .boot_step_o(boot_step_o));

// >>> verification/rss_far_model.sv
// far side: reset pin, detectors, main_osc ticks
`timescale 1ns/1ps
module rss_far_model (
   input  wire logic clk_i,        // internal_osc clock
   input  wire logic pin_req_i,    // hold the pin low
   input  wire logic por_req_i,    // supply still ramping
   input  wire logic droop_req_i,  // supply below droop threshold
   input  wire logic ldo_req_i,    // regulator out of regulation
   output logic      ext_rst_n_o,  // pin level
   output logic      por_o,        // power-on detector
   output logic      droop_o,      // droop comparator
   output logic      ldo_o,        // regulator status
   output logic      tick_o        // main_osc tick
);
   logic [1:0] div_r;       // main_osc tick every third clock
   logic       por_done_r;  // first ramp only
   initial begin
      {div_r, tick_o, droop_o, ldo_o, por_done_r} = '0;
      ext_rst_n_o = 1'b1;
      por_o = 1'b1;
   end
   // pads settle just after an edge
   always @(posedge clk_i) begin
      div_r       <= (div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
      tick_o      <= (div_r == 2'h0);
      ext_rst_n_o <= !pin_req_i;                   // pull-up lifts a released pin
      por_o       <= por_req_i && !por_done_r;
      if (!por_req_i) begin
         por_done_r <= 1'b1;
      end
      droop_o     <= droop_req_i;
      ldo_o       <= ldo_req_i;
   end
endmodule

// >>> verification/rss_seq_bench.sv
// reset sequencer bench
`timescale 1ns/1ps
module rss_seq_bench;
   logic clk = 0, nrst = 0, wr = 0, rd = 0, rd_pend = 0;  // clock, reset, strobes
   logic [7:0]  addr = 8'h00;      // register address
   logic [31:0] wdata = 32'h0, rdata, exp_f = 32'h2, r;  // bus data, expected flags
   logic wto = 0, wpend = 0, wen = 0, pin_q = 0, por_q = 1, drp_q = 0, ldo_q = 0;
   logic pin_n, por, drp, ldo, tick, core_n, test_n;  // partner and design outputs
   logic [7:0] prst;              // peripheral resets
   logic [1:0] boot;              // boot fetch step
   logic [31:0] exp_q[$];         // expected read data, oldest first
   int n_errors = 0, samples_checked = 0, n;
   always #20 clk = ~clk;
   rss_far_model u_rss_far_model (.clk_i(clk), .pin_req_i(pin_q), .por_req_i(por_q),
      .droop_req_i(drp_q), .ldo_req_i(ldo_q), .ext_rst_n_o(pin_n), .por_o(por),
      .droop_o(drp), .ldo_o(ldo), .tick_o(tick));
   rss_seq #(.SETTLE_TICKS(20), .DROOP_CLR_CYC(30)) u_rss_seq (.clk_i(clk), .nrst_i(nrst),
      .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .ext_rst_n_i(pin_n), .por_i(por), .droop_det_i(drp), .wdog_timeout_i(wto),
      .wdog_int_pend_i(wpend), .wdog_rst_en_i(wen), .ldo_unreg_i(ldo),
      .main_osc_tick_i(tick), .core_rst_n_o(core_n), .periph_rst_o(prst),
      .test_rst_n_o(test_n), .boot_step_o(boot));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask
   // read data stands one cycle
   always @(posedge clk) begin
      if (rd_pend) chk("rdata", exp_q.pop_front(), rdata);
      rd_pend <= rd;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk); addr <= a; wdata <= d; wr <= 1;
      @(posedge clk); wr <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk); addr <= a; rd <= 1; exp_q.push_back(e);
      @(posedge clk); rd <= 0;
   endtask
   task automatic end_of_test();
      $display("checked %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // bounded wait for boot, then its steps
   task automatic wait_boot();
      for (n = 0; n < 2000 && boot !== 2'h1; n++) begin
         @(posedge clk); #1;
      end
      if (n == 2000) begin
         n_errors++;
         end_of_test();
      end
      chk("core_n", 1, core_n);
      @(posedge clk); #1 chk("boot", 2, boot);
      @(posedge clk); #1 chk("boot", 3, boot);
   endtask
   initial begin
      void'($urandom(45));
      repeat (3) @(posedge clk);
      nrst <= 1;
      repeat (6) @(posedge clk);
      por_q <= 0;  // detector clears last
      wait_boot();
      chk("settle", 1, n >= 57);
      chk("test_n", 1, test_n);
      rd_reg(8'h00, 32'h2);
      rd_reg(8'h08, 32'h100);
      rd_reg(8'h04, 32'h0);
      rd_reg(8'h44, 32'h0);
      r = $urandom & 32'hff;
      wr_reg(8'h10, r);
      @(posedge clk); #1 chk("periph", r, {24'h0, prst});
      rd_reg(8'h10, r);
      wr_reg(8'h10, 32'h0);
      @(posedge clk); #1 chk("periph", 0, {24'h0, prst});
      $display("test power-on done");
      wen <= 1;
      @(posedge clk); wto <= 1;
      @(posedge clk); wto <= 0;  // first time-out alone must not reset
      repeat (10) @(posedge clk);
      #1 chk("core_n", 1, core_n);
      wpend <= 1;
      for (int k = 0; k < 4; k++) begin
         case (k)
            0: wr_reg(8'h0c, 32'h1);
            1: begin @(posedge clk); wto <= 1; @(posedge clk); wto <= 0; end
            2: begin wr_reg(8'h0c, 32'h2); ldo_q <= 1; repeat (2) @(posedge clk); ldo_q <= 0; end
            default: begin wr_reg(8'h04, 32'h2); drp_q <= 1; repeat (2) @(posedge clk); drp_q <= 0; end
         endcase
         exp_f |= 32'h1 << (k == 3 ? 2 : k + 3);
         wait_boot();
         rd_reg(8'h00, exp_f);
         chk("test_n", 1, test_n);
         $display("test source %0d done", k);
      end
      @(posedge clk); pin_q <= 1;
      repeat (12) @(posedge clk);
      #1 chk("core_n", 0, core_n);
      chk("periph", 32'hff, {24'h0, prst});
      pin_q <= 0;
      wait_boot();
      chk("settle", 1, n >= 57);
      rd_reg(8'h00, 32'h1);
      chk("test_n", 1, test_n);
      wr_reg(8'h00, 32'h1);
      rd_reg(8'h00, 32'h0);
      repeat (3) @(posedge clk);
      $display("test pin reset done");
      end_of_test();
   end
endmodule
